// *** src/mrs_top.sv ***
// Mode routing, transmit sequencer, receive framing and calibration with AXI4-Lite registers.
// Assumes a single 50 MHz clock; demodulator samples and sync hits arrive on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "mrs_consts.svh"

module mrs_top
  import mrs_pkg::*;
#(
  parameter int TICK_CYC = `MRS_TICK_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mrs_pair_s rx_in,
  input wire logic [15:0] demod_rrc,
  input wire logic sync_hit,
  input wire logic sync_base,
  input wire logic ana_valid,
  input wire logic [7:0] rx_byte,
  output mrs_pair_s aud_out,
  output logic transmit_enable_line,
  output logic receive_enable_line,
  output logic [7:0] power_ramp_converter,
  output logic ramp_out_en,
  output logic lna_on,
  output logic [7:0] ext_gain,
  output logic [7:0] int_gain,
  output logic [7:0] rxf_data,
  output logic rxf_valid,
  output logic rxf_last,
  output logic [7:0] rxf_slot
);
  initial begin
    if (TICK_CYC < 1) $error("TICK_CYC must be at least one");
  end

  // ==========================================================
  // Register file
  logic [15:0] mode_q, level_q, route_q, iqcfg_q, txload_q;
  logic [7:0] irq_q;
  logic [31:0] seq_q, ramp_q;
  logic [15:0] cal_q [3];
  logic [7:0] slot_q;
  logic cal_done_q, cal_busy_q, chan_base_q, dmr_only_q, ana_only_q;
  logic aw_q, w_q;
  logic [11:0] awa_q;
  logic [31:0] wd_q;
  logic wr_go, mode_wr, transmit_finished_irq_set, fs_set, rxf_set, ev_set;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  assign mode_wr = wr_go && awa_q == `MRS_OFF_MODE;

  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 12'h000;
      wd_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awa_q > `MRS_OFF_SLOT || awa_q[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q <= 16'h0000;
      level_q <= 16'h0000;
      route_q <= 16'h0000;
      iqcfg_q <= 16'h0000;
      seq_q <= 32'h0;
      ramp_q <= 32'h0;
      txload_q <= 16'h0000;
    end else if (wr_go && s_axi_wstrb[0]) begin
      case (awa_q)
        `MRS_OFF_MODE: mode_q <= wd_q[15:0];
        `MRS_OFF_LEVEL: level_q <= wd_q[15:0];
        `MRS_OFF_ROUTE: route_q <= wd_q[15:0];
        `MRS_OFF_IQCFG: iqcfg_q <= wd_q[15:0];
        `MRS_OFF_SEQ: seq_q <= wd_q;
        `MRS_OFF_RAMP: ramp_q <= wd_q;
        `MRS_OFF_TXLOAD: txload_q <= wd_q[15:0];
        default: ;
      endcase
    end
  end

  // Sticky flags, set beats clear (write one to clear)
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_q <= 8'h00;
    end else begin
      irq_q <= (irq_q & ~((wr_go && awa_q == `MRS_OFF_IRQ) ? wd_q[7:0] : 8'h00))
        | ({7'h0, transmit_finished_irq_set} << `MRS_IRQ_TRANSMIT_FINISHED_IRQ)
        | ({7'h0, fs_set} << `MRS_IRQ_FSYNC)
        | ({7'h0, rxf_set} << `MRS_IRQ_RXFIFO)
        | ({7'h0, ev_set} << `MRS_IRQ_EVENT);
    end
  end

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    case (a)
      `MRS_OFF_MODE: rd_mux = {16'h0, mode_q};
      `MRS_OFF_LEVEL: rd_mux = {16'h0, level_q};
      `MRS_OFF_ROUTE: rd_mux = {16'h0, route_q};
      `MRS_OFF_IRQ: rd_mux = {24'h0, irq_q};
      `MRS_OFF_STATUS: rd_mux = {27'h0, ana_only_q, dmr_only_q, chan_base_q, cal_busy_q,
        cal_done_q};
      `MRS_OFF_SEQ: rd_mux = seq_q;
      `MRS_OFF_RAMP: rd_mux = ramp_q;
      `MRS_OFF_IQCFG: rd_mux = {16'h0, iqcfg_q};
      `MRS_OFF_CAL0: rd_mux = {16'h0, cal_q[0]};
      `MRS_OFF_CAL1: rd_mux = {16'h0, cal_q[1]};
      `MRS_OFF_CAL2: rd_mux = {16'h0, cal_q[2]};
      `MRS_OFF_TXLOAD: rd_mux = {16'h0, txload_q};
      `MRS_OFF_SLOT: rd_mux = {24'h0, slot_q};
      default: rd_mux = 32'h0;
    endcase
  endfunction

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux(s_axi_araddr);
      s_axi_rresp <= (s_axi_araddr > `MRS_OFF_SLOT || s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // ==========================================================
  // Symbol tick and slot timing
  logic [15:0] div_q, tick_cnt_q;
  logic tick;
  assign tick = div_q == 16'(TICK_CYC - 1);
  always_ff @(posedge mclk) begin
    if (srst || tick) div_q <= 16'h0;
    else div_q <= div_q + 16'h1;
  end

  logic [3:0] txm, rxm;
  logic rx_active, slot_end, tx_slot_loaded;
  assign txm = mode_q[7:4];
  assign rxm = mode_q[3:0];
  assign rx_active = (rxm == `MRS_RX_RAW || rxm == `MRS_RX_DMR || rxm == `MRS_RX_RAW_ANA
    || rxm == `MRS_RX_DMR_ANA) && mode_q != `MRS_CAL_MODE;
  assign slot_end = tick && tick_cnt_q == `MRS_SLOT_TICKS - 16'h1;
  assign tx_slot_loaded = txload_q[slot_q[3:0]] && (txm == `MRS_TX_RAW || txm == `MRS_TX_DMR);

  logic synced_q;
  always_ff @(posedge mclk) begin
    if (srst || !rx_active || mode_wr) begin
      synced_q <= 1'b0;
      tick_cnt_q <= 16'h0;
      slot_q <= 8'h00;
      chan_base_q <= 1'b0;
    end else if (!synced_q && sync_hit) begin
      synced_q <= 1'b1;
      tick_cnt_q <= 16'h0;
      chan_base_q <= sync_base;
    end else if (synced_q && tick) begin
      tick_cnt_q <= slot_end ? 16'h0 : tick_cnt_q + 16'h1;
      if (slot_end) slot_q <= slot_q + 8'h01;
    end
  end
  assign fs_set = rx_active && !mode_wr && !synced_q && sync_hit;

  // Combined mode path selection
  always_ff @(posedge mclk) begin
    if (srst || mode_wr) begin
      dmr_only_q <= 1'b0;
      ana_only_q <= 1'b0;
    end else if (rxm == `MRS_RX_DMR_ANA && !dmr_only_q && !ana_only_q) begin
      if (fs_set) dmr_only_q <= 1'b1;
      else if (ana_valid) ana_only_q <= 1'b1;
    end
  end

  // ==========================================================
  // Receive block framing
  logic [5:0] bcnt_q;
  logic out_q, zero_q;
  always_ff @(posedge mclk) begin
    if (srst || !rx_active || ana_only_q) begin
      out_q <= 1'b0;
      zero_q <= 1'b0;
      bcnt_q <= 6'h0;
    end else if (synced_q && slot_end) begin
      out_q <= !tx_slot_loaded;
      zero_q <= tx_slot_loaded;
      bcnt_q <= 6'h0;
    end else if (out_q) begin
      bcnt_q <= bcnt_q + 6'h1;
      if (bcnt_q == 6'(`MRS_RAW_BYTES - 1)) out_q <= 1'b0;
    end else begin
      zero_q <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxf_valid <= 1'b0;
      rxf_last <= 1'b0;
      rxf_data <= 8'h00;
      rxf_slot <= 8'h00;
    end else begin
      rxf_valid <= out_q;
      rxf_last <= (out_q && bcnt_q == 6'(`MRS_RAW_BYTES - 1)) || zero_q;
      rxf_data <= rx_byte;
      rxf_slot <= slot_q;
    end
  end
  assign rxf_set = (out_q && bcnt_q == 6'(`MRS_RAW_BYTES - 1)) || zero_q;

  // ==========================================================
  // Output routing
  logic [15:0] lpf_q;
  logic [15:0] sync_pulse;
  function automatic logic [15:0] lvl(input logic [15:0] s, input logic [3:0] g);
    lvl = 16'($signed(s) >>> (4'hf - g));
  endfunction
  assign sync_pulse = (tick_cnt_q == 16'h0) ? 16'h7fff : 16'h0000;
  always_ff @(posedge mclk) begin
    if (srst) lpf_q <= 16'h0;
    else lpf_q <= lpf_q + 16'($signed(rx_in.in2 - lpf_q) >>> `MRS_LPF_SHIFT);
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      aud_out <= '0;
    end else begin
      case (txm)
        `MRS_TX_LPF: aud_out <= '{16'h0, lvl(lpf_q, level_q[3:0])};
        `MRS_TX_EYE: aud_out <= '{demod_rrc, sync_pulse};
        `MRS_TX_PASS: aud_out <= '{lvl(rx_in.in1, level_q[3:0]),
          lvl(rx_in.in2, level_q[3:0])};
        default: aud_out <= '0;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) receive_enable_line <= 1'b0;
    else receive_enable_line <= rxm != 4'h0 && !(synced_q && tx_slot_loaded);
  end

  // ==========================================================
  // Transmit sequencer
  mrs_seq_e st_q;
  logic [15:0] st_cnt_q;
  logic [7:0] ramp_lvl_q;
  logic bit_en_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= SEQ_IDLE;
      st_cnt_q <= 16'h0;
      bit_en_q <= 1'b0;
    end else if (tick) begin
      st_cnt_q <= st_cnt_q + 16'h1;
      case (st_q)
        SEQ_IDLE: if (synced_q && tx_slot_loaded && tick_cnt_q == {8'h0, seq_q[7:0]}) begin
          st_q <= SEQ_START;
          st_cnt_q <= 16'h0;
          bit_en_q <= txload_q[8 + `MRS_TRANSMIT_FINISHED_IRQ_EN_BIT];
        end
        SEQ_START: if (st_cnt_q == {8'h0, seq_q[15:8]}) begin
          st_q <= SEQ_RAMPU;
          st_cnt_q <= 16'h0;
        end
        SEQ_RAMPU: if (st_cnt_q == {8'h0, seq_q[31:24]}) begin
          st_q <= SEQ_HOLD;
          st_cnt_q <= 16'h0;
        end
        SEQ_HOLD: if (st_cnt_q == {8'h0, seq_q[23:16]}) begin
          st_q <= SEQ_RAMPD;
          st_cnt_q <= 16'h0;
        end
        SEQ_RAMPD: if (st_cnt_q == {8'h0, seq_q[31:24]}) st_q <= SEQ_IDLE;
        default: st_q <= SEQ_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      transmit_enable_line <= 1'b0;
      ramp_out_en <= 1'b0;
      ramp_lvl_q <= 8'h00;
    end else begin
      transmit_enable_line <= st_q != SEQ_IDLE;
      ramp_out_en <= st_q != SEQ_IDLE;
      if (st_q == SEQ_IDLE || st_q == SEQ_START) ramp_lvl_q <= ramp_q[7:0];
      else if (tick && st_q == SEQ_RAMPU && ramp_lvl_q != ramp_q[15:8]) ramp_lvl_q <= ramp_lvl_q + 8'h01;
      else if (tick && st_q == SEQ_RAMPD && ramp_lvl_q != ramp_q[7:0]) ramp_lvl_q <= ramp_lvl_q - 8'h01;
    end
  end
  assign power_ramp_converter = ramp_lvl_q;
  assign transmit_finished_irq_set = transmit_enable_line && st_q == SEQ_IDLE && bit_en_q;

  // ==========================================================
  // Gain control and calibration
  logic [15:0] cal_cnt_q;
  logic [15:0] acc_q;
  logic [7:0] agc_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      agc_q <= 8'h80;
    end else if (tick) begin
      if (rx_in.in1 > `MRS_AGC_HI && agc_q != 8'h00) agc_q <= agc_q - 8'h01;
      else if (rx_in.in1 < `MRS_AGC_LO && agc_q != 8'hff) agc_q <= agc_q + 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      int_gain <= 8'h00;
      ext_gain <= 8'h00;
      lna_on <= 1'b0;
    end else begin
      int_gain <= iqcfg_q[`MRS_AGC_BIT] ? route_q[15:8] : agc_q;
      ext_gain <= iqcfg_q[`MRS_AGC_BIT] ? route_q[7:0] : agc_q;
      lna_on <= mode_q != `MRS_CAL_MODE;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      cal_busy_q <= 1'b0;
      cal_done_q <= 1'b0;
      cal_cnt_q <= 16'h0;
      acc_q <= 16'h0;
      cal_q <= '{16'h0, 16'h0, 16'h0};
    end else if (mode_wr && wd_q[15:0] == `MRS_CAL_MODE) begin
      cal_busy_q <= 1'b1;
      cal_done_q <= 1'b0;
      cal_cnt_q <= 16'h0;
      acc_q <= 16'h0;
    end else if (cal_busy_q && tick) begin
      acc_q <= acc_q + (rx_in.in1 >>> 6) + (rx_in.in2 >>> 6);
      cal_cnt_q <= cal_cnt_q + 16'h1;
      if (cal_cnt_q == `MRS_CAL_TICKS - 16'h1) begin
        cal_busy_q <= 1'b0;
        cal_done_q <= 1'b1;
        cal_q <= '{rx_in.in1, rx_in.in2, acc_q};
      end
    end
  end
  assign ev_set = cal_busy_q && tick && cal_cnt_q == `MRS_CAL_TICKS - 16'h1;

  // ==========================================================
  // Checks
  a_transmit_finished_irq_flag: assert property (@(posedge mclk) disable iff (srst)
    transmit_finished_irq_set |=> irq_q[`MRS_IRQ_TRANSMIT_FINISHED_IRQ]) else $error("finished flag missing");
  a_ramp_gate: assert property (@(posedge mclk) disable iff (srst)
    ramp_out_en == transmit_enable_line) else $error("ramp active without enable");
  a_idle_reset: assert property (@(posedge mclk) disable iff (srst)
    rxm == `MRS_RX_IDLE |=> !synced_q) else $error("sync kept in idle");
  a_mode_restart: assert property (@(posedge mclk) disable iff (srst)
    mode_wr |=> slot_q == 8'h00 && !synced_q) else $error("rewrite kept slot");
  a_lna_cal: assert property (@(posedge mclk) disable iff (srst)
    mode_q == `MRS_CAL_MODE |=> !lna_on) else $error("lna on in calibration");
  a_cal_event: assert property (@(posedge mclk) disable iff (srst)
    ev_set |=> cal_done_q && irq_q[`MRS_IRQ_EVENT]) else $error("cal done lost");
  a_zero_block: assert property (@(posedge mclk) disable iff (srst)
    zero_q |-> !out_q) else $error("data in suppressed slot");
  a_fs_irq: assert property (@(posedge mclk) disable iff (srst)
    fs_set |=> synced_q && irq_q[`MRS_IRQ_FSYNC]) else $error("sync irq missing");
  a_gain_manual: assert property (@(posedge mclk) disable iff (srst)
    iqcfg_q[`MRS_AGC_BIT] |=> int_gain == $past(route_q[15:8]))
    else $error("manual gain ignored");
  c_tx_burst: cover property (@(posedge mclk) st_q == SEQ_RAMPD);
  c_raw_block: cover property (@(posedge mclk) rxf_last && rxf_valid);
  c_cal_done: cover property (@(posedge mclk) ev_set);
endmodule
`default_nettype wire

// *** src/mrs_consts.svh ***
// Offsets, field positions, mode codes and timing counts of the mode/sequencer block.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH

// Register byte offsets
`define MRS_OFF_MODE      12'h000
`define MRS_OFF_LEVEL     12'h004
`define MRS_OFF_ROUTE     12'h008
`define MRS_OFF_IRQ       12'h00c
`define MRS_OFF_STATUS    12'h010
`define MRS_OFF_SEQ       12'h014
`define MRS_OFF_RAMP      12'h018
`define MRS_OFF_IQCFG     12'h01c
`define MRS_OFF_CAL0      12'h020
`define MRS_OFF_CAL1      12'h024
`define MRS_OFF_CAL2      12'h028
`define MRS_OFF_TXLOAD    12'h02c
`define MRS_OFF_EVENT     12'h030
`define MRS_OFF_SLOT      12'h034

// Mode field codes
`define MRS_RX_IDLE       4'h1
`define MRS_RX_RAW        4'h2
`define MRS_RX_DMR        4'h3
`define MRS_RX_RAW_ANA    4'h6
`define MRS_RX_DMR_ANA    4'h7
`define MRS_RX_CAL        4'hf
`define MRS_TX_RAW        4'h2
`define MRS_TX_DMR        4'h3
`define MRS_TX_LPF        4'hd
`define MRS_TX_EYE        4'he
`define MRS_TX_PASS       4'hf
`define MRS_CAL_MODE      16'h000f

// IRQ status bits and the transmit-finished enable bit
`define MRS_IRQ_TRANSMIT_FINISHED_IRQ    2
`define MRS_IRQ_FSYNC     3
`define MRS_IRQ_RXFIFO    4
`define MRS_IRQ_EVENT     5
`define MRS_TRANSMIT_FINISHED_IRQ_EN_BIT 2

// Timing: tick of 1/6 symbol at 4800 baud
`define MRS_CLK_HZ        50000000
`define MRS_BAUD          4800
`define MRS_TICK_DIV      6
`define MRS_TICK_CYC      (`MRS_CLK_HZ / (`MRS_BAUD * `MRS_TICK_DIV))
`define MRS_RAW_BYTES     36
`define MRS_SLOT_TICKS    16'd864
`define MRS_CAL_TICKS     16'd64
`define MRS_LPF_SHIFT     4
`define MRS_AGC_HI        16'h6000
`define MRS_AGC_LO        16'h1000
`define MRS_AGC_BIT       2

`endif

// *** src/mrs_pkg.sv ***
// Types of the mode/sequencer block.
// Assumes mrs_consts.svh is on the include path.
package mrs_pkg;
  typedef enum logic [4:0] {
    SEQ_IDLE  = 5'b00001,
    SEQ_START = 5'b00010,
    SEQ_RAMPU = 5'b00100,
    SEQ_HOLD  = 5'b01000,
    SEQ_RAMPD = 5'b10000
  } mrs_seq_e;
  typedef struct packed {
    logic [15:0] in1;
    logic [15:0] in2;
  } mrs_pair_s;
endpackage

// *** verification/mrs_host_model.sv ***
// Host model: register master on the block's AXI4-Lite port.
// Assumes one clock shared with the block; one write and one read at a time.
`timescale 1ns/100ps
`default_nettype none
module mrs_host_model (
  input wire logic mclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // ==========================================
  // Write: address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    do @(posedge mclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // ==========================================
  // Read
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge mclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verification/mrs_tb_top.sv ***
// Self-checking bench: routing modes, receive framing, calibration, gain, sequencer.
// Assumes TICK_CYC of 2, so one slot lasts 1728 clock cycles.
`timescale 1ns/100ps
`default_nettype none
`include "mrs_consts.svh"
module modem_rx_modes_tx_sequencer_tb_top
  import mrs_pkg::*;
;
  logic mclk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v, rnd;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [3:0] s_axi_wstrb = 4'hf;
  mrs_pair_s rx_in, aud_out;
  logic [15:0] demod_rrc;
  logic [7:0] rx_byte, power_ramp_converter, ext_gain, int_gain, rxf_data, rxf_slot;
  logic sync_hit, sync_base, ana_valid, transmit_enable_line, receive_enable_line;
  logic ramp_out_en, lna_on, rxf_valid, rxf_last;
  logic sup_seen = 1'b0;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  int nb;

  mrs_top #(.TICK_CYC(2)) dut (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_in, .demod_rrc, .sync_hit, .sync_base, .ana_valid,
    .rx_byte, .aud_out, .transmit_enable_line, .receive_enable_line, .power_ramp_converter,
    .ramp_out_en, .lna_on, .ext_gain, .int_gain, .rxf_data, .rxf_valid, .rxf_last, .rxf_slot);
  mrs_host_model host (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] mode_w(input logic [3:0] tx, input logic [3:0] rx);
    return {24'h000000, tx, rx};
  endfunction
  function automatic logic [31:0] bit_m(input int b);
    return 32'h00000001 << b;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic mode(input logic [31:0] m);
    host.wr(`MRS_OFF_MODE, m, resp);
    repeat (4) @(posedge mclk);
  endtask
  task automatic pulse_sync();
    sync_hit <= 1'b1;
    @(posedge mclk);
    sync_hit <= 1'b0;
  endtask
  task automatic wait_lvl(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 8000) begin
      @(posedge mclk);
      n++;
    end
    cmp(32'(n < 8000), 32'h1);
  endtask
  task automatic complete_run();
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================
  // Background stimulus and timeout
  always @(posedge mclk) begin
    rx_byte <= 8'($urandom);
    if (rxf_last && !rxf_valid) sup_seen <= 1'b1;
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h692d));
    {srst, rx_in, demod_rrc, sync_hit, sync_base, ana_valid} = {1'b1, 51'h0};
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    host.rd(`MRS_OFF_MODE, rd_v, resp);
    cmp(rd_v, 32'h0);
    host.rd(12'h038, rd_v, resp);
    cmp({rd_v[29:0], resp}, 32'h2);
    host.wr(12'h03c, 32'h1234, resp);
    cmp(32'(resp), 32'h2);
    rnd = $urandom;
    host.wr(`MRS_OFF_IQCFG, bit_m(`MRS_AGC_BIT), resp);
    host.wr(`MRS_OFF_ROUTE, {16'h0, rnd[15:0]}, resp);
    mode(mode_w(4'h0, `MRS_RX_DMR));
    cmp(32'(int_gain), 32'(rnd[15:8]));
    cmp(32'(ext_gain), 32'(rnd[7:0]));
    host.wr(`MRS_OFF_LEVEL, 32'hf, resp);
    mode(mode_w(`MRS_TX_PASS, 4'h0));
    for (int i = 0; i < 3; i++) begin
      rx_in <= {16'($urandom), 16'($urandom)};
      repeat (4) @(posedge mclk);
      cmp(aud_out, rx_in);
    end
    mode(mode_w(`MRS_TX_EYE, 4'h0));
    demod_rrc <= 16'($urandom);
    repeat (4) @(posedge mclk);
    cmp(32'(aud_out.in1), 32'(demod_rrc));
    mode(mode_w(`MRS_TX_LPF, 4'h0));
    rx_in <= {16'h0, 16'h0400};
    repeat (300) @(posedge mclk);
    cmp(32'(aud_out.in2 > 16'h03e0 && aud_out.in2 <= 16'h0400), 32'h1);
    mode(mode_w(4'h0, `MRS_RX_IDLE));
    cmp(32'(receive_enable_line), 32'h1);
    mode(mode_w(4'h0, `MRS_RX_DMR_ANA));
    ana_valid <= 1'b1;
    @(posedge mclk);
    ana_valid <= 1'b0;
    host.rd(`MRS_OFF_STATUS, rd_v, resp);
    cmp(rd_v & 32'h18, 32'h10);
    host.wr(`MRS_OFF_IRQ, 32'h3f, resp);
    mode(mode_w(4'h0, `MRS_RX_RAW));
    pulse_sync();
    wait_lvl(rxf_valid, 1'b1);
    nb = 0;
    repeat (100) begin
      if (rxf_valid) nb++;
      if (rxf_last) break;
      @(posedge mclk);
    end
    cmp(32'(nb), 32'(`MRS_RAW_BYTES));
    host.rd(`MRS_OFF_IRQ, rd_v, resp);
    cmp(rd_v & 32'h18, 32'h18);
    mode(mode_w(4'h0, `MRS_RX_DMR));
    host.rd(`MRS_OFF_SLOT, rd_v, resp);
    cmp(rd_v, 32'h0);
    mode(`MRS_CAL_MODE);
    cmp(32'(lna_on), 32'h0);
    repeat (200) @(posedge mclk);
    host.rd(`MRS_OFF_STATUS, rd_v, resp);
    cmp(rd_v & 32'h1, 32'h1);
    host.rd(`MRS_OFF_IRQ, rd_v, resp);
    cmp(rd_v & bit_m(`MRS_IRQ_EVENT), bit_m(`MRS_IRQ_EVENT));
    host.rd(`MRS_OFF_CAL2, rd_v, resp);
    cmp(32'(resp), 32'h0);
    mode(mode_w(4'h0, `MRS_RX_DMR));
    cmp(32'(lna_on), 32'h1);
    host.wr(`MRS_OFF_IRQ, 32'h3f, resp);
    host.wr(`MRS_OFF_SEQ, 32'h02040302, resp);
    host.rd(`MRS_OFF_SEQ, rd_v, resp);
    cmp(rd_v, 32'h02040302);
    host.wr(`MRS_OFF_RAMP, 32'h00008000, resp);
    mode(mode_w(`MRS_TX_RAW, `MRS_RX_RAW));
    pulse_sync();
    host.wr(`MRS_OFF_TXLOAD, 32'h0000ffff, resp);
    wait_lvl(transmit_enable_line, 1'b1);
    cmp(32'({ramp_out_en, power_ramp_converter}), 32'h100);
    @(posedge mclk);
    cmp(32'(power_ramp_converter), 32'h0);
    repeat (12) @(posedge mclk);
    cmp(32'(power_ramp_converter != 8'h00), 32'h1);
    wait_lvl(transmit_enable_line, 1'b0);
    repeat (2) @(posedge mclk);
    cmp(32'(ramp_out_en), 32'h0);
    host.rd(`MRS_OFF_IRQ, rd_v, resp);
    cmp(rd_v & bit_m(`MRS_IRQ_TRANSMIT_FINISHED_IRQ), bit_m(`MRS_IRQ_TRANSMIT_FINISHED_IRQ));
    repeat (1800) @(posedge mclk);
    cmp(32'(sup_seen), 32'h1);
    host.wr(`MRS_OFF_TXLOAD, 32'h0, resp);
    mode(32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
